// >>> rtl/usbsc_map.svh
`ifndef USBSC_MAP_SVH
`define USBSC_MAP_SVH

// ****************
// register offsets
// ****************
`define USBSC_OFF_STAT 12'h000
`define USBSC_OFF_CON 12'h004
`define USBSC_OFF_ADDR 12'h008
`define USBSC_OFF_TOK 12'h00c
`define USBSC_OFF_SOF 12'h010

// ****************
// field positions
// ****************
`define USBSC_STAT_EP_LSB 4
`define USBSC_STAT_DIR 3
`define USBSC_STAT_ODD 2
`define USBSC_CON_JST 7
`define USBSC_CON_SE0 6
`define USBSC_CON_B5 5
`define USBSC_CON_BRST 4
`define USBSC_CON_HOST 3
`define USBSC_CON_RES 2
`define USBSC_CON_PPC 1
`define USBSC_CON_B0 0
`define USBSC_ADDR_LS 7
`define USBSC_TOK_PID_LSB 4

// ****************
// token codes
// ****************
`define USBSC_PID_SETUP 4'hd
`define USBSC_PID_IN 4'h9
`define USBSC_PID_OUT 4'h1

// ****************
// reset values
// ****************
`define USBSC_RST_BYTE 8'h00
`define USBSC_RST_NIB 4'h0
`define USBSC_RST_DP_IDLE 1'b1

// ****************
// timing
// ****************
`define USBSC_CLK_PS 25000
`define USBSC_FRAME_PS 1000000000
`define USBSC_FRAME_CYCLES (`USBSC_FRAME_PS / `USBSC_CLK_PS)
`define USBSC_BYTE_PS 666667
`define USBSC_BYTE_CYCLES (`USBSC_BYTE_PS / `USBSC_CLK_PS)

`endif

// >>> rtl/usbsc_pkg.sv
package usbsc_pkg;

  typedef enum logic [2:0] {
    USBSC_TK_IDLE = 3'b001,
    USBSC_TK_PEND = 3'b010,
    USBSC_TK_BUSY = 3'b100
  } usbsc_tok_st_t;

  typedef struct packed {
    logic dp_s1;
    logic dp_s2;
    logic dm_s1;
    logic dm_s2;
    logic se0;
    logic jst;
    logic [3:0] stat_ep;
    logic stat_tx;
    logic stat_odd;
    logic pkt_halt;
    logic host_en;
    logic resume;
    logic pp_clr;
    logic attach_en;
    logic bus_rst;
    logic sof_en;
    logic [6:0] addr;
    logic low_spd;
    logic [3:0] tok_pid;
    logic [3:0] tok_ep;
    logic [7:0] thr;
    usbsc_tok_st_t tok_st;
    logic [15:0] frame_cnt;
    logic sof_pulse;
    logic tok_start;
    logic dp_pullup;
    logic dp_pulldn;
    logic dm_pulldn;
    logic ls_out;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } usbsc_state_t;

endpackage

// >>> rtl/usbsc_top.sv
// What this block does
// - after each transfer, load four-bit status with the updated endpoint number
// - direction status bit: 1 for transmit, 0 for receive
// - odd-bank status bit: 1 odd bank, 0 even bank used last
// - live single-ended-zero flag, read only, in both modes
// - device mode: halt flag stops token processing; a SETUP token sets it
// - host enable turns on host operation and both data-line pull-downs
// - resume signalling driven while resume control is set
// - writing ping-pong clear returns all pointers to the even bank
// - device mode: attach enable switches module on and D+ pull-up
// - host mode: live J-state flag, speed-dependent polarity
// - host mode: token-busy is 1 while a token is executing
// - host mode: frame start enable sends one start-of-frame per millisecond
// - host mode speed select: 1 low, 0 full; reads 0 in device mode
// - seven-bit writable device address used on the bus
// - host token types: 1101 SETUP, 1001 IN, 0001 OUT
// - with OTG features off, pulls follow host enable and attach enable
`include "usbsc_map.svh"

module usbsc_top
  import usbsc_pkg::*;
#(
  parameter int FRAME_CYCLES = `USBSC_FRAME_CYCLES
) (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic pready_out,
  output logic pslverr_out,
  output logic [31:0] prdata_out,
  input wire logic dp_in,
  input wire logic dm_in,
  input wire logic otg_features_on_in,
  input wire logic xfer_done_in,
  input wire logic [3:0] xfer_ep_in,
  input wire logic xfer_tx_in,
  input wire logic xfer_odd_in,
  input wire logic setup_rcvd_in,
  input wire logic token_done_in,
  output logic token_start_out,
  output logic [3:0] token_pid_out,
  output logic [3:0] token_endpoint_out,
  output logic frame_start_out,
  output logic token_processing_halt_out,
  output logic host_enable_out,
  output logic resume_drive_out,
  output logic bus_reset_drive_out,
  output logic pingpong_pointer_clear_out,
  output logic dp_pullup_out,
  output logic dp_pulldown_out,
  output logic dm_pulldown_out,
  output logic low_speed_select_out,
  output logic [6:0] device_address_out
);

  // ****************
  // helpers
  // ****************
  function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] off);
    reg_hit = (a == off);
  endfunction

  function automatic logic pid_valid(input logic [3:0] p);
    pid_valid = (p == `USBSC_PID_SETUP) || (p == `USBSC_PID_IN) || (p == `USBSC_PID_OUT);
  endfunction

  usbsc_state_t st_q;
  usbsc_state_t st_d;

  logic apb_setup;
  logic apb_wr;
  logic mapped;
  logic [7:0] rd_byte;
  logic [15:0] guard_cycles;
  logic frame_room;

  // ****************
  // next state
  // ****************
  always_comb begin
    st_d = st_q;
    apb_setup = psel_in && !penable_in;
    apb_wr = psel_in && penable_in && st_q.pready && pwrite_in;
    mapped = reg_hit(paddr_in, `USBSC_OFF_STAT) || reg_hit(paddr_in, `USBSC_OFF_CON)
      || reg_hit(paddr_in, `USBSC_OFF_ADDR) || reg_hit(paddr_in, `USBSC_OFF_TOK)
      || reg_hit(paddr_in, `USBSC_OFF_SOF);
    // threshold counts bytes; frame counter counts clocks
    guard_cycles = 16'(st_q.thr * `USBSC_BYTE_CYCLES);
    frame_room = !st_q.sof_en || (st_q.frame_cnt >= guard_cycles);

    // line synchronisers; first stage feeds only the second
    st_d.dp_s1 = dp_in;
    st_d.dp_s2 = st_q.dp_s1;
    st_d.dm_s1 = dm_in;
    st_d.dm_s2 = st_q.dm_s1;
    st_d.se0 = !st_q.dp_s2 && !st_q.dm_s2;
    // J is differential 0 at low speed, 1 at full speed
    st_d.jst = st_q.host_en && (st_q.low_spd ? (!st_q.dp_s2 && st_q.dm_s2)
      : (st_q.dp_s2 && !st_q.dm_s2));

    // all three fields from one event, never mixed
    if (xfer_done_in) begin
      st_d.stat_ep = xfer_ep_in;
      st_d.stat_tx = xfer_tx_in;
      st_d.stat_odd = xfer_odd_in;
    end

    // register writes take effect at the access edge
    if (apb_wr && reg_hit(paddr_in, `USBSC_OFF_CON)) begin
      st_d.host_en = pwdata_in[`USBSC_CON_HOST];
      st_d.resume = pwdata_in[`USBSC_CON_RES];
      st_d.pp_clr = pwdata_in[`USBSC_CON_PPC];
      if (st_q.host_en) begin
        st_d.bus_rst = pwdata_in[`USBSC_CON_BRST];
        st_d.sof_en = pwdata_in[`USBSC_CON_B0];
      end else begin
        st_d.pkt_halt = pwdata_in[`USBSC_CON_B5];
        st_d.attach_en = pwdata_in[`USBSC_CON_B0];
      end
    end
    if (apb_wr && reg_hit(paddr_in, `USBSC_OFF_ADDR)) begin
      st_d.addr = pwdata_in[6:0];
      st_d.low_spd = pwdata_in[`USBSC_ADDR_LS];
    end
    if (apb_wr && reg_hit(paddr_in, `USBSC_OFF_TOK)) begin
      st_d.tok_pid = pwdata_in[7:4];
      st_d.tok_ep = pwdata_in[3:0];
    end
    if (apb_wr && reg_hit(paddr_in, `USBSC_OFF_SOF)) begin
      st_d.thr = pwdata_in[7:0];
    end
    // a SETUP arriving during a software clear still halts
    if (setup_rcvd_in && !st_q.host_en) begin
      st_d.pkt_halt = 1'b1;
    end
    if (!st_q.host_en) begin
      st_d.bus_rst = 1'b0;
      st_d.sof_en = 1'b0;
    end

    // frame timer, idle at full count so the first frame is whole
    st_d.sof_pulse = 1'b0;
    if (st_q.host_en && st_q.sof_en) begin
      if (st_q.frame_cnt == 16'h0000) begin
        st_d.frame_cnt = 16'(FRAME_CYCLES - 1);
        st_d.sof_pulse = 1'b1;
      end else begin
        st_d.frame_cnt = st_q.frame_cnt - 16'h0001;
      end
    end else begin
      st_d.frame_cnt = 16'(FRAME_CYCLES - 1);
    end

    // token launcher
    st_d.tok_start = 1'b0;
    case (st_q.tok_st)
      USBSC_TK_IDLE: begin
        // reserved codes are dropped, nothing launches
        if (apb_wr && reg_hit(paddr_in, `USBSC_OFF_TOK) && st_q.host_en
            && pid_valid(pwdata_in[7:4])) begin
          st_d.tok_st = USBSC_TK_PEND;
        end
      end
      USBSC_TK_PEND: begin
        // host check here too: a pending token must not launch in the disable cycle
        if (st_q.host_en && !st_q.bus_rst && !st_q.sof_pulse && frame_room) begin
          st_d.tok_st = USBSC_TK_BUSY;
          st_d.tok_start = 1'b1;
        end
      end
      USBSC_TK_BUSY: begin
        if (token_done_in) begin
          st_d.tok_st = USBSC_TK_IDLE;
        end
      end
      default: begin
        st_d.tok_st = USBSC_TK_IDLE;
      end
    endcase
    if (!st_q.host_en) begin
      st_d.tok_st = USBSC_TK_IDLE;
    end

    // pad drive; OTG logic elsewhere owns the pulls when its features are on
    st_d.dp_pullup = !otg_features_on_in && !st_q.host_en && st_q.attach_en;
    st_d.dp_pulldn = !otg_features_on_in && st_q.host_en;
    st_d.dm_pulldn = !otg_features_on_in && st_q.host_en;
    st_d.ls_out = st_q.host_en && st_q.low_spd;

    // read mux, sampled in the setup cycle
    rd_byte = `USBSC_RST_BYTE;
    if (reg_hit(paddr_in, `USBSC_OFF_STAT)) begin
      rd_byte = {st_q.stat_ep, st_q.stat_tx, st_q.stat_odd, 2'b00};
    end else if (reg_hit(paddr_in, `USBSC_OFF_CON)) begin
      if (st_q.host_en) begin
        rd_byte = {st_q.jst, st_q.se0, st_q.tok_st != USBSC_TK_IDLE, st_q.bus_rst,
          st_q.host_en, st_q.resume, st_q.pp_clr, st_q.sof_en};
      end else begin
        rd_byte = {1'b0, st_q.se0, st_q.pkt_halt, 1'b0,
          st_q.host_en, st_q.resume, st_q.pp_clr, st_q.attach_en};
      end
    end else if (reg_hit(paddr_in, `USBSC_OFF_ADDR)) begin
      rd_byte = {st_q.low_spd && st_q.host_en, st_q.addr};
    end else if (reg_hit(paddr_in, `USBSC_OFF_TOK)) begin
      rd_byte = {st_q.tok_pid, st_q.tok_ep};
    end else if (reg_hit(paddr_in, `USBSC_OFF_SOF)) begin
      rd_byte = st_q.thr;
    end

    // one wait-free access cycle per transfer
    st_d.pready = apb_setup;
    st_d.pslverr = apb_setup && !mapped;
    if (apb_setup) begin
      st_d.prdata = {24'h000000, rd_byte};
    end
  end

  // ****************
  // state register
  // ****************
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q <= '0;
      // line syncs start at full-speed idle, so no false se0 after reset
      st_q.dp_s1 <= `USBSC_RST_DP_IDLE;
      st_q.dp_s2 <= `USBSC_RST_DP_IDLE;
      st_q.tok_st <= USBSC_TK_IDLE;
      st_q.frame_cnt <= 16'h0000;
    end else begin
      st_q <= st_d;
    end
  end

  assign pready_out = st_q.pready;
  assign pslverr_out = st_q.pslverr;
  assign prdata_out = st_q.prdata;
  assign token_start_out = st_q.tok_start;
  assign token_pid_out = st_q.tok_pid;
  assign token_endpoint_out = st_q.tok_ep;
  assign frame_start_out = st_q.sof_pulse;
  assign token_processing_halt_out = st_q.pkt_halt;
  assign host_enable_out = st_q.host_en;
  assign resume_drive_out = st_q.resume;
  assign bus_reset_drive_out = st_q.bus_rst;
  assign pingpong_pointer_clear_out = st_q.pp_clr;
  assign dp_pullup_out = st_q.dp_pullup;
  assign dp_pulldown_out = st_q.dp_pulldn;
  assign dm_pulldown_out = st_q.dm_pulldn;
  assign low_speed_select_out = st_q.ls_out;
  assign device_address_out = st_q.addr;

  // ****************
  // checks
  // ****************
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!arst_n_in);

  sequence apb_setup_s;
    psel_in && !penable_in;
  endsequence

  sequence apb_access_s;
    psel_in && penable_in;
  endsequence

  sequence se0_held_s;
    (!dp_in && !dm_in) [*3];
  endsequence

  sequence dp_high_s;
    dp_in [*3];
  endsequence

  sequence con_write_s;
    apb_access_s ##0 (pready_out && pwrite_in && reg_hit(paddr_in, `USBSC_OFF_CON));
  endsequence

  sequence addr_write_s;
    apb_access_s ##0 (pready_out && pwrite_in && reg_hit(paddr_in, `USBSC_OFF_ADDR));
  endsequence

  stat_endpoint_a: assert property (xfer_done_in |=> st_q.stat_ep == $past(xfer_ep_in))
    else $error("endpoint status not loaded");

  stat_dir_a: assert property (xfer_done_in |=> st_q.stat_tx == $past(xfer_tx_in))
    else $error("direction status not loaded");

  stat_odd_a: assert property (xfer_done_in |=> st_q.stat_odd == $past(xfer_odd_in))
    else $error("bank status not loaded");

  stat_together_a: assert property (!xfer_done_in |=> $stable(st_q.stat_ep)
      && $stable(st_q.stat_tx) && $stable(st_q.stat_odd))
    else $error("status changed without a transfer");

  se0_live_a: assert property (se0_held_s |=> st_q.se0)
    else $error("se0 flag missed");

  se0_clear_a: assert property (dp_high_s |=> !st_q.se0)
    else $error("se0 flag stuck");

  line_j_flag_device_a: assert property (!host_enable_out |=> !st_q.jst)
    else $error("j flag outside host mode");

  halt_setup_a: assert property (setup_rcvd_in && !st_q.host_en |=> token_processing_halt_out)
    else $error("setup did not halt");

  pullup_attach_a: assert property (!otg_features_on_in && !st_q.host_en && st_q.attach_en
      |=> dp_pullup_out && !dp_pulldown_out)
    else $error("attach pull-up wrong");

  host_pulls_a: assert property (!otg_features_on_in && host_enable_out
      |=> dp_pulldown_out && dm_pulldown_out && !dp_pullup_out)
    else $error("host pull-downs wrong");

  otg_pulls_a: assert property (otg_features_on_in
      |=> !dp_pullup_out && !dp_pulldown_out && !dm_pulldown_out)
    else $error("pulls driven under otg control");

  host_write_a: assert property (con_write_s |=> host_enable_out == $past(pwdata_in[3]))
    else $error("host enable not written");

  resume_write_a: assert property (con_write_s |=> resume_drive_out == $past(pwdata_in[2]))
    else $error("resume drive not written");

  ppclr_write_a: assert property (con_write_s
      |=> pingpong_pointer_clear_out == $past(pwdata_in[1]))
    else $error("pointer clear not written");

  addr_write_a: assert property (addr_write_s
      |=> device_address_out == $past(pwdata_in[6:0]))
    else $error("device address not written");

  speed_device_a: assert property (!host_enable_out |=> !low_speed_select_out)
    else $error("low speed outside host mode");

  reset_device_a: assert property (!host_enable_out |=> !bus_reset_drive_out)
    else $error("bus reset outside host mode");

  sof_device_a: assert property (!host_enable_out |=> !frame_start_out)
    else $error("frame start outside host mode");

  sof_gap_a: assert property (frame_start_out |=> !frame_start_out [*8])
    else $error("frame starts too close");

  sof_host_a: assert property (frame_start_out |-> $past(st_q.host_en && st_q.sof_en))
    else $error("frame start without enable");

  tok_room_a: assert property (token_start_out |-> $past(frame_room)
      && st_q.tok_st == USBSC_TK_BUSY)
    else $error("token started without room");

  tok_code_a: assert property (token_start_out |-> pid_valid(token_pid_out))
    else $error("reserved token launched");

  tok_busy_a: assert property (st_q.tok_st == USBSC_TK_BUSY && !token_done_in
      && host_enable_out |=> st_q.tok_st == USBSC_TK_BUSY)
    else $error("token busy dropped early");

  tok_clear_a: assert property (st_q.tok_st == USBSC_TK_BUSY && token_done_in
      |=> st_q.tok_st == USBSC_TK_IDLE)
    else $error("token busy held after done");

  apb_answer_a: assert property (apb_setup_s |=> pready_out ##1 !pready_out)
    else $error("apb answer timing wrong");

  apb_error_a: assert property (pslverr_out |-> pready_out)
    else $error("slave error outside access");

endmodule

// >>> tb/usbsc_bus_model.sv
// ***
// far-side bus model: line levels and token replies
// ***
module usbsc_bus_model (
  input wire logic clock_in,
  input wire logic [1:0] bus_state_in,
  input wire logic [7:0] lag_in,
  input wire logic token_start_in,
  output logic dp_out,
  output logic dm_out,
  output logic token_done_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // lines follow the commanded state; no pulls modelled
  assign dp_out = bus_state_in[1];
  assign dm_out = bus_state_in[0];
  // lag sets a prompt or a slow reply
  initial begin
    token_done_out = 1'h0;
    // launch seen mid-cycle, replies driven on rising edges
    forever begin
      @(negedge clock_in);
      if (token_start_in === 1'h1) begin
        repeat (lag_in) @(posedge clock_in);
        token_done_out <= 1'h1;
        @(posedge clock_in);
        token_done_out <= 1'h0;
      end
    end
  end
endmodule

// >>> tb/usb_sie_status_control_test.sv
`include "usbsc_map.svh"
module usb_sie_status_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in, arst_n_in, psel, penable, pwrite, otg, xdone, xtx, xodd, setup;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] xep, tpid, tep;
  logic [1:0] bst;
  logic [7:0] lag;
  logic [6:0] dadr;
  logic pready, pslverr, tstart, sof, halt, hen, res, brst, ppc, pu, pdp, pdm, ls;
  logic dp, dm, tdone;
  int err_count = 0, num_checks = 0, cyc = 0, ntok, nsof, n;
  logic [3:0] pids [3] = '{4'hd, 4'h9, 4'h1};
  logic [3:0] eps [3] = '{4'h0, 4'h5, 4'hf};
  usbsc_top #(.FRAME_CYCLES(1024)) u_usbsc_top (.clock_in(clock_in), .arst_n_in(arst_n_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .pready_out(pready), .pslverr_out(pslverr), .prdata_out(prdata),
    .dp_in(dp), .dm_in(dm), .otg_features_on_in(otg), .xfer_done_in(xdone),
    .xfer_ep_in(xep), .xfer_tx_in(xtx), .xfer_odd_in(xodd), .setup_rcvd_in(setup),
    .token_done_in(tdone), .token_start_out(tstart), .token_pid_out(tpid),
    .token_endpoint_out(tep), .frame_start_out(sof), .token_processing_halt_out(halt),
    .host_enable_out(hen), .resume_drive_out(res), .bus_reset_drive_out(brst),
    .pingpong_pointer_clear_out(ppc), .dp_pullup_out(pu), .dp_pulldown_out(pdp),
    .dm_pulldown_out(pdm), .low_speed_select_out(ls), .device_address_out(dadr));
  usbsc_bus_model u_usbsc_bus_model (.clock_in(clock_in), .bus_state_in(bst), .lag_in(lag),
    .token_start_in(tstart), .dp_out(dp), .dm_out(dm), .token_done_out(tdone));
  // ***
  // clock, timeout, verdict
  // ***
  initial begin
    clock_in = 1'h0;
    forever #12.5 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  // ***
  // apb master and helpers
  // ***
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic ee);
    int k;
    k = 0;
    @(posedge clock_in);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'h1;
    // look mid-cycle, where registered answers have settled
    do begin
      @(negedge clock_in);
      k++;
    end while (pready !== 1'h1 && k < 50);
    chk("pready", 1, pready);
    if (!w) chk("prdata", e, prdata);
    chk("pslverr", {31'h0, ee}, {31'h0, pslverr});
    // access edge: write lands, then release
    @(posedge clock_in);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0, e, 1'h0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'h1, a, d, 32'h0, 1'h0);
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clock_in);
  endtask
  task automatic line(input logic [1:0] s);
    @(posedge clock_in);
    bst <= s;
    step(4);
  endtask
  task automatic xfer(input logic [3:0] e, input logic t, input logic o);
    @(posedge clock_in);
    xdone <= 1'h1;
    xep <= e;
    xtx <= t;
    xodd <= o;
    @(posedge clock_in);
    xdone <= 1'h0;
    xep <= ~e;
    xtx <= ~t;
    xodd <= ~o;
  endtask
  task automatic wait_tok();
    int k;
    k = 0;
    do begin
      @(negedge clock_in);
      k++;
    end while (tstart !== 1'h1 && k < 1200);
    chk("start", 1, tstart);
  endtask
  task automatic wait_done();
    int k;
    k = 0;
    do begin
      @(negedge clock_in);
      k++;
    end while (tdone !== 1'h1 && k < 100);
    chk("done", 1, tdone);
    // busy falls only at the edge that takes done
    @(posedge clock_in);
  endtask
  task automatic wait_sof();
    n = 0;
    do begin
      @(negedge clock_in);
      n++;
    end while (sof !== 1'h1 && n < 2000);
    chk("sof", 1, sof);
  endtask
  task automatic cnt(input int k);
    ntok = 0;
    nsof = 0;
    repeat (k) begin
      @(negedge clock_in);
      if (tstart === 1'h1) ntok++;
      if (sof === 1'h1) nsof++;
    end
  endtask
  // ***
  // main sequence
  // ***
  initial begin
    arst_n_in = 1'h0;
    {psel, penable, pwrite, otg, xdone, xtx, xodd, setup} = 8'h00;
    paddr = 12'h0;
    pwdata = 32'h0;
    xep = 4'h0;
    bst = 2'h2;
    lag = 8'h06;
    step(4);
    arst_n_in <= 1'h1;
    for (int i = 0; i < 5; i++) rd(12'(i * 4), 32'h0);
    bus(1'h0, 12'h014, 32'h0, 32'h0, 1'h1);
    xfer(4'hf, 1'h1, 1'h0);
    rd(`USBSC_OFF_STAT, 32'hf8);
    xfer(4'h0, 1'h0, 1'h1);
    rd(`USBSC_OFF_STAT, 32'h04);
    wr(`USBSC_OFF_STAT, 32'hff);
    rd(`USBSC_OFF_STAT, 32'h04);
    wr(`USBSC_OFF_CON, 32'h01);
    step(2);
    chk("pulls", 3'h4, {pu, pdp, pdm});
    @(posedge clock_in);
    setup <= 1'h1;
    @(posedge clock_in);
    setup <= 1'h0;
    step(2);
    chk("halt", 1, halt);
    rd(`USBSC_OFF_CON, 32'h21);
    wr(`USBSC_OFF_CON, 32'h07);
    step(2);
    chk("resume", 1, res);
    chk("ppclr", 1, ppc);
    wr(`USBSC_OFF_CON, 32'h01);
    step(2);
    chk("resume", 0, {halt, res});
    @(posedge clock_in);
    otg <= 1'h1;
    step(3);
    chk("otg pulls", 0, pu);
    otg <= 1'h0;
    wr(`USBSC_OFF_ADDR, 32'h8a);
    rd(`USBSC_OFF_ADDR, 32'h0a);
    chk("addr", {1'h0, 7'h0a}, {ls, dadr});
    wr(`USBSC_OFF_CON, 32'h08);
    step(2);
    chk("host pulls", 4'hb, {hen, pu, pdp, pdm});
    rd(`USBSC_OFF_ADDR, 32'h8a);
    chk("low speed", 1, ls);
    line(2'h1);
    rd(`USBSC_OFF_CON, 32'h88);
    line(2'h2);
    rd(`USBSC_OFF_CON, 32'h08);
    wr(`USBSC_OFF_ADDR, 32'h0a);
    // j flag follows the new speed one edge later
    step(2);
    rd(`USBSC_OFF_CON, 32'h88);
    line(2'h0);
    rd(`USBSC_OFF_CON, 32'h48);
    line(2'h2);
    wr(`USBSC_OFF_CON, 32'h18);
    step(2);
    chk("bus reset", 1, brst);
    wr(`USBSC_OFF_CON, 32'h08);
    step(2);
    chk("bus reset", 0, brst);
    for (int i = 0; i < 3; i++) begin
      lag <= (i == 1) ? 8'h28 : 8'h06;
      wr(`USBSC_OFF_TOK, {24'h0, pids[i], eps[i]});
      wait_tok();
      chk("token", {pids[i], eps[i]}, {tpid, tep});
      rd(`USBSC_OFF_CON, 32'ha8);
      wait_done();
      rd(`USBSC_OFF_CON, 32'h88);
    end
    wr(`USBSC_OFF_TOK, 32'h53);
    cnt(30);
    chk("reserved", 0, ntok);
    rd(`USBSC_OFF_CON, 32'h88);
    // thr 0x4a needs more frame time than a 1024-cycle frame has
    wr(`USBSC_OFF_SOF, 32'h4a);
    wr(`USBSC_OFF_CON, 32'h09);
    wait_sof();
    wait_sof();
    chk("sof period", 1024, n);
    wr(`USBSC_OFF_TOK, 32'h93);
    cnt(1100);
    chk("late token", 0, ntok);
    wr(`USBSC_OFF_SOF, 32'h0a);
    wait_tok();
    wait_done();
    wr(`USBSC_OFF_CON, 32'h08);
    cnt(1100);
    chk("sof off", 0, nsof);
    final_report();
  end
endmodule
